/* srg_supervisor_regs.vh */
// Constants for the supply supervisor with gated serial EEPROM.
// Assumes a single system clock whose rate is given in MHz below.
`ifndef SRG_SUPERVISOR_REGS_VH
`define SRG_SUPERVISOR_REGS_VH

`define SRG_CLK_MHZ        25
`define SRG_SPIKE_NS       100
`define SRG_GLITCH_NS      30
`define SRG_MAN_GLITCH_NS  100
`define SRG_RST_TIMEOUT_US 200000
`define SRG_WC_US          5000
// Cycle counts of the two intervals at the 25 MHz clock above; keep them in step with it.
`define SRG_RST_TIMEOUT_CYC 24'h4C4B40
`define SRG_WC_CYC          24'h01E848
`define SRG_BUS_FREE_NS    1300
`define SRG_SLAVE_ADDR     7'h50
`define SRG_PAGE_BITS      4
`define SRG_ADDR_BITS      8
`define SRG_CNT_BITS       24

`endif

/* srg_supervisor.v */
// Supply supervisor with reset timeout and an I2C EEPROM slave gated by reset.
// Assumes sys_clk_i is free running; all pins are asynchronous, and all inputs but resetn_i are
// synchronised and glitch filtered here before any logic looks at them.
`timescale 1ns/10ps
`include "srg_supervisor_regs.vh"

// Operation
// RULE_01: A page or byte write finishes its internal cycle within 5 ms of the stop that ends it.
// RULE_02: While the internal write runs, the bus interface is off, SDA stays released and the address is not acknowledged.
// RULE_03: Pulses up to 100 ns on SDA and SCL are never taken as edges, starts or stops.
// RULE_04: The master leaves the bus idle at least 1.3 us after a stop before a new start.
// RULE_05: Supply dips of 30 ns or less below threshold produce no reset.
// RULE_06: Low pulses up to 100 ns on the manual reset input produce no reset.
// RULE_07: Reset outputs assert within 1 us of the manual reset input going low.
// RULE_08: Reset outputs assert within 5 us of the supply falling below threshold.
// RULE_09: The master waits up to 270 ms after the supply is stable before a memory read.
// RULE_10: The master waits up to 270 ms after the supply is stable before a memory write.
// RULE_11: At power-up reset is held until the supply is good and then for the 200 ms timeout.
// RULE_12: Reset holds while manual reset is low and for one full timeout after it returns high.
// RULE_13: Active reset aborts any transfer and refuses new ones, but a started internal write still completes.
// RULE_14: The master treats a missing address acknowledge as busy and retries for up to 5 ms.
// RULE_15: Reset and write intervals are timed by internal counters on the device's own clock.
module srg_supervisor #(
    parameter [23:0] RST_TIMEOUT_CYC = `SRG_RST_TIMEOUT_CYC,
    parameter [23:0] WRITE_CYCLE_CYC = `SRG_WC_CYC,
    parameter [6:0]  SLAVE_ADDR      = `SRG_SLAVE_ADDR
) (
    input  wire sys_clk_i,
    input  wire resetn_i,
    input  wire supply_ok_i,
    input  wire manual_reset_input_n_i,
    input  wire scl_i,
    input  wire sda_i,
    output wire sda_o,
    output wire sda_oe_n_o,
    output wire reset_n_o,
    output wire reset_n_oe_n_o,
    output wire reset_o,
    output wire reset_oe_n_o,
    output wire write_busy_o
);

    localparam integer SPIKE_RAW  = (`SRG_SPIKE_NS * `SRG_CLK_MHZ + 999) / 1000;
    localparam integer GLITCH_RAW = (`SRG_GLITCH_NS * `SRG_CLK_MHZ + 999) / 1000;
    localparam integer MAN_RAW    = (`SRG_MAN_GLITCH_NS * `SRG_CLK_MHZ + 999) / 1000;
    localparam [2:0]   SPIKE_THR  = SPIKE_RAW[2:0];
    localparam [2:0]   GLITCH_THR = GLITCH_RAW[2:0];
    localparam [2:0]   MAN_THR    = MAN_RAW[2:0];

    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_RX   = 5'h02;
    localparam [4:0] ST_ACK  = 5'h04;
    localparam [4:0] ST_TX   = 5'h08;
    localparam [4:0] ST_MACK = 5'h10;

    localparam [1:0] KIND_DEV  = 2'h0;
    localparam [1:0] KIND_WORD = 2'h1;
    localparam [1:0] KIND_DATA = 2'h2;

    // Channel order: 0 SCL, 1 SDA, 2 manual reset, 3 supply good.
    localparam [3:0] PIN_IDLE = 4'h7;

    reg  [3:0]                sync1_reg;
    reg  [3:0]                sync2_reg;
    reg  [3:0]                filt_reg;
    reg  [3:0]                filt_q_reg;
    reg  [2:0]                fcnt_reg [0:3];
    reg                       rst_act_reg;
    reg  [`SRG_CNT_BITS-1:0]  rst_cnt_reg;
    reg                       busy_reg;
    reg  [`SRG_CNT_BITS-1:0]  busy_cnt_reg;
    reg  [4:0]                state_reg;
    reg  [1:0]                kind_reg;
    reg  [3:0]                bit_reg;
    reg  [7:0]                shift_reg;
    reg                       rw_reg;
    reg                       sda_drv_reg;
    reg  [`SRG_ADDR_BITS-1:0] waddr_reg;
    reg  [15:0]               mask_reg;
    reg  [7:0]                mem [0:255];
    reg  [7:0]                page_buf [0:15];
    integer                   i;
    integer                   j;

    wire scl_f      = filt_reg[0];
    wire sda_f      = filt_reg[1];
    wire scl_rise   = filt_reg[0] & ~filt_q_reg[0];
    wire scl_fall   = ~filt_reg[0] & filt_q_reg[0];
    wire start_ev   = filt_q_reg[1] & ~sda_f & scl_f & filt_q_reg[0];
    wire stop_ev    = ~filt_q_reg[1] & sda_f & scl_f & filt_q_reg[0];
    wire rx_done    = (state_reg == ST_RX) && scl_fall && (bit_reg == 4'h8);
    wire bus_quiet  = ~start_ev & ~stop_ev & ~rst_act_reg;
    wire page_we    = rx_done && (kind_reg == KIND_DATA) && bus_quiet;
    wire commit     = stop_ev & (|mask_reg) & ~rst_act_reg & ~busy_reg;
    wire [7:0] rd_byte = mem[waddr_reg];

    function [2:0] filt_thr;
        input integer ch;
        begin
            case (ch)
                2:       filt_thr = MAN_THR;
                3:       filt_thr = GLITCH_THR;
                default: filt_thr = SPIKE_THR;
            endcase
        end
    endfunction

    // A new level is taken only after it has been seen on more samples than the
    // widest pulse to be rejected can cover; SCL and SDA get the same delay so
    // their relative order, and hence start and stop detection, is preserved.
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_reg  <= PIN_IDLE;
            sync2_reg  <= PIN_IDLE;
            filt_reg   <= PIN_IDLE;
            filt_q_reg <= PIN_IDLE;
            for (i = 0; i < 4; i = i + 1) begin
                fcnt_reg[i] <= 3'h0;
            end
        end else begin
            sync1_reg  <= {supply_ok_i, manual_reset_input_n_i, sda_i, scl_i};
            sync2_reg  <= sync1_reg;
            filt_q_reg <= filt_reg;
            for (i = 0; i < 4; i = i + 1) begin
                if (sync2_reg[i] == filt_reg[i]) begin
                    fcnt_reg[i] <= 3'h0;
                end else if (fcnt_reg[i] == filt_thr(i)) begin // [RULE_03] [RULE_05] [RULE_06]
                    filt_reg[i] <= sync2_reg[i];
                    fcnt_reg[i] <= 3'h0;
                end else begin
                    fcnt_reg[i] <= fcnt_reg[i] + 3'h1;
                end
            end
        end
    end

    // Reset is held while either cause is present and the timeout restarts
    // from zero each time, so the release always follows a full period.
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_act_reg <= 1'b1;
            rst_cnt_reg <= {`SRG_CNT_BITS{1'b0}};
        end else if (!filt_reg[3] || !filt_reg[2]) begin // [RULE_07] [RULE_08]
            rst_act_reg <= 1'b1;
            rst_cnt_reg <= {`SRG_CNT_BITS{1'b0}};
        end else if (rst_act_reg) begin
            if (rst_cnt_reg == RST_TIMEOUT_CYC - 24'h000001) begin // [RULE_11] [RULE_12] [RULE_15]
                rst_act_reg <= 1'b0;
            end else begin
                rst_cnt_reg <= rst_cnt_reg + 24'h000001;
            end
        end
    end

    // The internal write is not gated by reset once it has begun.
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_reg     <= 1'b0;
            busy_cnt_reg <= {`SRG_CNT_BITS{1'b0}};
        end else if (commit) begin
            busy_reg     <= 1'b1;
            busy_cnt_reg <= {`SRG_CNT_BITS{1'b0}};
        end else if (busy_reg) begin
            if (busy_cnt_reg == WRITE_CYCLE_CYC - 24'h000001) begin // [RULE_01] [RULE_13] [RULE_15]
                busy_reg <= 1'b0;
            end else begin
                busy_cnt_reg <= busy_cnt_reg + 24'h000001;
            end
        end
    end

    // Array storage has no reset; the page buffer is committed as a whole so
    // an aborted sequence leaves the array untouched.
    always @(posedge sys_clk_i) begin
        if (page_we) begin
            page_buf[waddr_reg[3:0]] <= shift_reg;
        end
        if (commit) begin
            for (j = 0; j < 16; j = j + 1) begin
                if (mask_reg[j]) begin
                    mem[{waddr_reg[7:4], j[3:0]}] <= page_buf[j];
                end
            end
        end
    end

    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg   <= ST_IDLE;
            kind_reg    <= KIND_DEV;
            bit_reg     <= 4'h0;
            shift_reg   <= 8'h00;
            rw_reg      <= 1'b0;
            sda_drv_reg <= 1'b0;
            waddr_reg   <= 8'h00;
            mask_reg    <= 16'h0000;
        end else if (rst_act_reg) begin // [RULE_13]
            state_reg   <= ST_IDLE;
            sda_drv_reg <= 1'b0;
            mask_reg    <= 16'h0000;
        end else if (start_ev) begin
            sda_drv_reg <= 1'b0;
            mask_reg    <= 16'h0000;
            bit_reg     <= 4'h0;
            kind_reg    <= KIND_DEV;
            state_reg   <= busy_reg ? ST_IDLE : ST_RX; // [RULE_02]
        end else if (stop_ev) begin
            state_reg   <= ST_IDLE;
            sda_drv_reg <= 1'b0;
            mask_reg    <= 16'h0000;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    sda_drv_reg <= 1'b0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_f};
                        bit_reg   <= bit_reg + 4'h1;
                    end else if (rx_done) begin
                        bit_reg     <= 4'h0;
                        state_reg   <= ST_ACK;
                        sda_drv_reg <= 1'b1;
                        case (kind_reg)
                            KIND_DEV: begin
                                rw_reg <= shift_reg[0];
                                if (shift_reg[7:1] != SLAVE_ADDR || busy_reg) begin // [RULE_02]
                                    state_reg   <= ST_IDLE;
                                    sda_drv_reg <= 1'b0;
                                end
                            end
                            KIND_WORD: begin
                                waddr_reg <= shift_reg;
                            end
                            default: begin
                                mask_reg[waddr_reg[3:0]] <= 1'b1;
                                waddr_reg[3:0]           <= waddr_reg[3:0] + 4'h1;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (kind_reg == KIND_DEV && rw_reg) begin
                            shift_reg   <= rd_byte;
                            sda_drv_reg <= ~rd_byte[7];
                            waddr_reg   <= waddr_reg + 8'h01;
                            state_reg   <= ST_TX;
                        end else begin
                            sda_drv_reg <= 1'b0;
                            kind_reg    <= (kind_reg == KIND_DEV) ? KIND_WORD : KIND_DATA;
                            state_reg   <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_reg == 4'h7) begin
                            sda_drv_reg <= 1'b0;
                            bit_reg     <= 4'h0;
                            state_reg   <= ST_MACK;
                        end else begin
                            shift_reg   <= {shift_reg[6:0], 1'b0};
                            sda_drv_reg <= ~shift_reg[6];
                            bit_reg     <= bit_reg + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise && sda_f) begin
                        state_reg <= ST_IDLE;
                    end else if (scl_fall) begin
                        shift_reg   <= rd_byte;
                        sda_drv_reg <= ~rd_byte[7];
                        waddr_reg   <= waddr_reg + 8'h01;
                        state_reg   <= ST_TX;
                    end
                end
                default: begin
                    state_reg   <= ST_IDLE;
                    sda_drv_reg <= 1'b0;
                end
            endcase
        end
    end

    assign sda_o          = 1'b0;
    assign sda_oe_n_o     = ~sda_drv_reg;
    assign reset_n_o      = 1'b0;
    assign reset_n_oe_n_o = ~rst_act_reg;
    assign reset_o        = 1'b1;
    assign reset_oe_n_o   = ~rst_act_reg;
    assign write_busy_o   = busy_reg;

endmodule // srg_supervisor

/* srg_supervisor_sva.sv */
// Concurrent checks on the supervisor top module ports, attached by bind.
// Assumes every pin is driven away from the rising edge of sys_clk_i.
`timescale 1ns/10ps
module srg_supervisor_sva #(
    parameter [23:0] RST_TIMEOUT_CYC = 24'h4C4B40,
    parameter [23:0] WRITE_CYCLE_CYC = 24'h01E848
) (
    input wire sys_clk_i,
    input wire resetn_i,
    input wire supply_ok_i,
    input wire manual_reset_input_n_i,
    input wire scl_i,
    input wire sda_i,
    input wire sda_oe_n_o,
    input wire reset_n_oe_n_o,
    input wire reset_oe_n_o,
    input wire write_busy_o
);
    reg  [2:0]  man_run_reg;
    reg         sup_low_reg;
    reg  [4:0]  since_reg;
    reg  [23:0] quiet_reg;
    reg  [23:0] busy_reg;
    // A cause is a low level long enough that no filter may reject it.
    wire        cause = (!manual_reset_input_n_i && man_run_reg == 3'h7) || (!supply_ok_i && sup_low_reg);
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            man_run_reg <= 3'h0;
            sup_low_reg <= 1'h0;
            since_reg   <= 5'h1F;
            quiet_reg   <= 24'h000000;
            busy_reg    <= 24'h000000;
        end else begin
            man_run_reg <= manual_reset_input_n_i ? 3'h0 : {man_run_reg[1:0], 1'h1};
            sup_low_reg <= !supply_ok_i;
            since_reg   <= cause ? 5'h00 : since_reg + {4'h0, ~&since_reg};
            quiet_reg   <= (manual_reset_input_n_i & supply_ok_i) ? quiet_reg + {23'h0, ~&quiet_reg} : 24'h000000;
            busy_reg    <= write_busy_o ? busy_reg + 24'h000001 : 24'h000000;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_man_held; !manual_reset_input_n_i [*8]; endsequence
    sequence s_stop_seen; scl_i && sda_i && !$past(sda_i, 12); endsequence
    property p_man_assert; s_man_held |-> ##[0:25] !reset_n_oe_n_o; endproperty
    property p_supply_assert; !supply_ok_i [*2] |-> ##[0:125] !reset_n_oe_n_o; endproperty
    property p_no_false; $fell(reset_n_oe_n_o) |-> since_reg <= 5'h0C; endproperty
    property p_release_hold; $rose(reset_n_oe_n_o) |-> quiet_reg >= RST_TIMEOUT_CYC; endproperty
    property p_release_bound; quiet_reg == RST_TIMEOUT_CYC + 24'h00001E |-> reset_n_oe_n_o && reset_oe_n_o; endproperty
    property p_busy_silent; write_busy_o |-> sda_oe_n_o; endproperty
    property p_busy_len; write_busy_o |-> busy_reg < WRITE_CYCLE_CYC; endproperty
    property p_busy_start; $rose(write_busy_o) |-> s_stop_seen; endproperty
    property p_reset_silent; !reset_n_oe_n_o [*4] |-> sda_oe_n_o; endproperty
    a_man_assert: assert property (p_man_assert) else $error("reset late after manual press");
    a_supply_assert: assert property (p_supply_assert) else $error("reset late after supply loss");
    a_no_false: assert property (p_no_false) else $error("reset without lasting cause");
    a_release_hold: assert property (p_release_hold) else $error("reset released early");
    a_release_bound: assert property (p_release_bound) else $error("reset not released");
    a_busy_silent: assert property (p_busy_silent) else $error("SDA driven while busy");
    a_busy_len: assert property (p_busy_len) else $error("write cycle too long");
    a_busy_start: assert property (p_busy_start) else $error("write cycle without stop");
    a_reset_silent: assert property (p_reset_silent) else $error("SDA driven in reset");
endmodule // srg_supervisor_sva
bind srg_supervisor srg_supervisor_sva #(.RST_TIMEOUT_CYC(RST_TIMEOUT_CYC), .WRITE_CYCLE_CYC(WRITE_CYCLE_CYC)) i_sva (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .supply_ok_i(supply_ok_i),
    .manual_reset_input_n_i(manual_reset_input_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_oe_n_o(sda_oe_n_o),
    .reset_n_oe_n_o(reset_n_oe_n_o), .reset_oe_n_o(reset_oe_n_o), .write_busy_o(write_busy_o));

/* srg_i2c_master_model.sv */
// Behavioural I2C bus master standing for the controller on the far side.
// Assumes SDA is resolved outside as a wired-AND with a pull-up and fed back.
`timescale 1ns/10ps
module srg_i2c_master_model (
    output logic scl_o,
    output logic sda_o,
    input  wire  sda_w_i
);
    // Half of the 320 ns link period; phases are stretched to meet the low and high minimums.
    localparam int T = 160;
    initial begin
        scl_o = 1'h1;
        sda_o = 1'h1;
    end
    task automatic start();
        sda_o = 1'h1;
        #(2*T) scl_o = 1'h1;
        #(4*T) sda_o = 1'h0;
        #(4*T) scl_o = 1'h0;
    endtask
    task automatic stop();
        #(2*T) sda_o = 1'h0;
        #(2*T) scl_o = 1'h1;
        #(4*T) sda_o = 1'h1;
        #(9*T); // Bus stays free 1.44 us before any new start.
    endtask
    task automatic clk_bit(input logic b, input logic spk, output logic s);
        #(2*T) sda_o = b;
        #(7*T) scl_o = 1'h1;
        #T;
        if (spk) begin
            sda_o = ~b;
            #80 sda_o = b;
            #T scl_o = 1'h0;
            #80 scl_o = 1'h1;
        end
        #T s = sda_w_i;
        #(2*T) scl_o = 1'h0;
    endtask
    task automatic wbyte(input logic [7:0] b, input logic spk, output logic ack_n);
        for (int i = 7; i >= 0; i--) clk_bit(b[i], spk, ack_n);
        clk_bit(1'h1, 1'h0, ack_n);
    endtask
    task automatic rbyte(output logic [7:0] b, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'h1, 1'h0, s);
            b[i] = s;
        end
        clk_bit(nack, 1'h0, s);
    endtask
    // A missing acknowledge means busy; retry gives up after roughly 5 ms.
    task automatic addr_poll(output int tries);
        logic a;
        tries = 0;
        start();
        wbyte(8'hA0, 1'h0, a);
        while (a && tries < 200) begin
            stop();
            tries++;
            start();
            wbyte(8'hA0, 1'h0, a);
        end
    endtask
endmodule // srg_i2c_master_model

/* tb.sv */
// Self-checking bench: reset timing, glitch rejection and reset-gated EEPROM access.
// Assumes the master model and a pull-up on SDA; timeouts are shortened by parameter.
`timescale 1ns/10ps
module tb;
    localparam [23:0] RST = 24'h0000C8;
    localparam [23:0] WCY = 24'h00012C;
    logic sys_clk_i, resetn_i, supply_ok_i, man_n;
    wire  scl, sda_m, sda_oe_n, sda_dev, rst_n_oe_n, rst_oe_n, busy, rst_n_val, rst_val;
    wire  sda_w = sda_m & (sda_oe_n | sda_dev);
    // Reset pins as the board sees them: a pull-up on the low-active one, a pull-down on the other.
    wire  rst_n_pin = rst_n_oe_n | rst_n_val;
    wire  rst_pin   = ~rst_oe_n & rst_val;
    int   num_errors = 0;
    int   compares = 0;
    srg_supervisor #(.RST_TIMEOUT_CYC(RST), .WRITE_CYCLE_CYC(WCY)) i_dut (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .supply_ok_i(supply_ok_i), .manual_reset_input_n_i(man_n),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_dev), .sda_oe_n_o(sda_oe_n), .reset_n_o(rst_n_val),
        .reset_n_oe_n_o(rst_n_oe_n), .reset_o(rst_val), .reset_oe_n_o(rst_oe_n), .write_busy_o(busy));
    srg_i2c_master_model i_mst (.scl_o(scl), .sda_o(sda_m), .sda_w_i(sda_w));
    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", w, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic close_out();
        $display("errors %0d, compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] w, input logic [7:0] d, input logic spk);
        logic a;
        i_mst.start();
        i_mst.wbyte(8'hA0, 1'h0, a);
        chk("address ack", 8'h00, 8'(a));
        i_mst.wbyte(w, 1'h0, a);
        chk("word ack", 8'h00, 8'(a));
        i_mst.wbyte(d, spk, a);
        chk("data ack", 8'h00, 8'(a));
        i_mst.stop();
    endtask
    task automatic rd_from(input logic [7:0] w, input logic [7:0] e);
        logic a;
        logic [7:0] d;
        i_mst.wbyte(w, 1'h0, a);
        i_mst.start();
        i_mst.wbyte(8'hA1, 1'h0, a);
        i_mst.rbyte(d, 1'h1);
        i_mst.stop();
        chk("read data", e, d);
    endtask
    task automatic t_power_up();
        cyc(RST - 20);
        chk("reset held", 8'h00, 8'(rst_n_oe_n | rst_oe_n));
        chk("reset pins held", 8'h01, 8'({rst_n_pin, rst_pin}));
        cyc(40);
        chk("reset released", 8'h01, 8'(rst_n_oe_n & rst_oe_n));
        chk("reset pins released", 8'h02, 8'({rst_n_pin, rst_pin}));
    endtask
    task automatic t_glitch();
        supply_ok_i = 1'h0;
        #30 supply_ok_i = 1'h1;
        cyc(4);
        // Set off the clock phase so the pulse spans three samples, the most a 100 ns pulse can.
        #10 man_n = 1'h0;
        #100 man_n = 1'h1;
        cyc(40);
        chk("reset after glitches", 8'h01, 8'(rst_n_oe_n));
    endtask
    task automatic t_write_busy();
        int n;
        wr(8'h12, 8'h5A, 1'h1);
        chk("busy after stop", 8'h01, 8'(busy));
        i_mst.addr_poll(n);
        chk("polls while busy", 8'h01, n[7:0]);
        rd_from(8'h12, 8'h5A);
        chk("busy over", 8'h00, 8'(busy));
    endtask
    task automatic t_manual();
        int n;
        logic a;
        wr(8'h20, 8'h33, 1'h0);
        man_n = 1'h0;
        cyc(25);
        chk("reset after press", 8'h00, 8'(rst_n_oe_n));
        chk("write runs on", 8'h01, 8'(busy));
        // Let the write cycle end first, so only reset can refuse the address below.
        cyc(WCY);
        chk("write done in reset", 8'h00, 8'(busy));
        i_mst.start();
        i_mst.wbyte(8'hA0, 1'h0, a);
        i_mst.stop();
        chk("ack in reset", 8'h01, 8'(a));
        cyc(RST);
        man_n = 1'h1;
        cyc(RST - 10);
        chk("reset after release", 8'h00, 8'(rst_n_oe_n));
        cyc(40);
        chk("reset ends", 8'h01, 8'(rst_n_oe_n));
        i_mst.addr_poll(n);
        chk("polls after reset", 8'h00, n[7:0]);
        rd_from(8'h20, 8'h33);
    endtask
    task automatic t_brownout();
        supply_ok_i = 1'h0;
        cyc(125);
        chk("reset after supply loss", 8'h00, 8'(rst_oe_n));
        supply_ok_i = 1'h1;
        cyc(RST + 40);
        chk("reset after supply back", 8'h01, 8'(rst_oe_n));
    endtask
    initial begin
        sys_clk_i = 1'h0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        resetn_i = 1'h0;
        supply_ok_i = 1'h1;
        man_n = 1'h1;
        cyc(6);
        resetn_i = 1'h1;
        t_power_up();
        t_glitch();
        t_write_busy(); // Memory is touched only once reset has lifted.
        t_manual();
        t_brownout();
        close_out();
    end
    // The whole run needs a little under 0.4 ms.
    initial begin
        #2000000;
        num_errors++;
        close_out();
    end
endmodule // tb
